// [inc/pbc_cfg.svh]
/*
 Bit positions, reset values and timing counts for the transceiver basic
 control register block. Assumes inclusion by bare name from inc/.
*/
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH

`define PBC_BIT_SPEED       13
`define PBC_BIT_AN_EN       12
`define PBC_BIT_PWR_DWN     11
`define PBC_BIT_AN_RESTART  9
`define PBC_BIT_DUPLEX      8
`define PBC_BIT_COL_TEST    7

`define PBC_RST_PWR_DWN     1'h0
`define PBC_RST_AN_RESTART  1'h0
`define PBC_RST_COL_TEST    1'h0
`define PBC_RST_EXT_SPEED   1'h1
`define PBC_RST_EXT_AN_EN   1'h0
`define PBC_RST_EXT_DUPLEX  1'h0

`define PBC_CLK_PERIOD_NS   10
`define PBC_TICK_NS         1000000
`define PBC_AN_TIMEOUT_MS   3000

`endif

// [inc/pbc_pkg.sv]
/*
 Types shared by the basic control block and its negotiation sequencer.
 Assumes pbc_cfg.svh supplies the numeric constants.
*/
package pbc_pkg;

   typedef enum logic [1:0] {
      PBC_NEG_IDLE = 2'b00,
      PBC_NEG_BUSY = 2'b01,
      PBC_NEG_DONE = 2'b10
   } pbc_neg_state_t;

   typedef struct packed {
      logic ok;
      logic speed_100;
      logic full_duplex;
   } pbc_partner_t;

   typedef struct packed {
      logic speed_100;
      logic full_duplex;
      logic power_down;
      logic collision;
   } pbc_link_cfg_t;

   typedef struct packed {
      logic speed_select;
      logic autoneg_enable;
      logic power_down;
      logic autoneg_restart;
      logic duplex_select;
      logic collision_test_enable;
      logic [15:0] rdata;
   } pbc_ctrl_state_t;

   typedef struct packed {
      pbc_neg_state_t state;
      logic [31:0]    tick_cnt;
      logic [31:0]    ms_cnt;
      logic           complete;
      logic           speed_100;
      logic           full_duplex;
   } pbc_neg_reg_t;

endpackage : pbc_pkg

// [hdl/pbc_negotiator.sv]
/*
 Auto-negotiation sequencer: runs after a start pulse, takes the partner
 result or falls back after a timeout, then raises the complete flag.
 Assumes mclk at 100 MHz and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "pbc_cfg.svh"

module pbc_negotiator #(
   parameter int unsigned TICK_CYC   = `PBC_TICK_NS / `PBC_CLK_PERIOD_NS,
   parameter int unsigned TIMEOUT_MS = `PBC_AN_TIMEOUT_MS
) (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  start,
   input  wire logic                  enable,
   input  wire pbc_pkg::pbc_partner_t partner,
   output logic                       complete,
   output logic                       speed_100,
   output logic                       full_duplex
);
   import pbc_pkg::*;

   pbc_neg_reg_t r_q;
   pbc_neg_reg_t r_d;

   always_comb begin
      r_d = r_q;
      // Millisecond enable from a divider
      if (r_q.state == PBC_NEG_BUSY) begin
         if (r_q.tick_cnt >= TICK_CYC - 1) begin
            r_d.tick_cnt = 32'h0;
            r_d.ms_cnt   = r_q.ms_cnt + 32'h1;
         end else begin
            r_d.tick_cnt = r_q.tick_cnt + 32'h1;
         end
      end
      case (r_q.state)
         PBC_NEG_IDLE: begin
            if (start && enable) begin
               r_d.state    = PBC_NEG_BUSY;
               r_d.tick_cnt = 32'h0;
               r_d.ms_cnt   = 32'h0;
            end
         end
         PBC_NEG_BUSY: begin
            if (partner.ok) begin
               r_d.state       = PBC_NEG_DONE;
               r_d.complete    = 1'b1;
               r_d.speed_100   = partner.speed_100;
               r_d.full_duplex = partner.full_duplex;
            end else if (r_q.ms_cnt >= TIMEOUT_MS) begin
               // Silent partner: lowest common mode
               r_d.state       = PBC_NEG_DONE;
               r_d.complete    = 1'b1;
               r_d.speed_100   = 1'b0;
               r_d.full_duplex = 1'b0;
            end
         end
         PBC_NEG_DONE: begin
            if (start && enable) begin
               r_d.state    = PBC_NEG_BUSY;
               r_d.complete = 1'b0;
               r_d.tick_cnt = 32'h0;
               r_d.ms_cnt   = 32'h0;
            end
         end
         default: begin
            r_d.state = PBC_NEG_IDLE;
         end
      endcase
      // Disable or power down aborts and drops the complete flag; speed and duplex keep their values
      if (!enable) begin
         r_d.state    = PBC_NEG_IDLE;
         r_d.complete = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   assign complete    = r_q.complete;
   assign speed_100   = r_q.speed_100;
   assign full_duplex = r_q.full_duplex;

endmodule : pbc_negotiator
`default_nettype wire

// [hdl/pbc_ctrl.sv]
/*
 Lower fields of the transceiver basic control register for one internal
 transceiver port, with strap-derived reset values and negotiation hookup.
 Assumes a management engine outside drives the register port, and that
 straps and mode inputs are stable while rst is high.
*/
// Summary of operation
// - With negotiation off, bit 13 picks 10 Mbps (0) or 100 Mbps (1).
// - Bit 12 enables negotiation, which then overrides manual speed and duplex.
// - Bit 11 written 1 enters general power down and written 0 leaves it.
// - After power down clears, negotiation may run and on finishing sets the complete flag.
// - Writing 1 to bit 9 restarts negotiation unless one is already running, and the bit clears itself.
// - With negotiation off, bit 8 picks half (0) or full (1) duplex.
// - Bit 7 set forces the collision indication during every transmission.
// - First port in an external mode resets the speed bit to 1 regardless of straps.
// - Otherwise the speed bit resets to the negotiation strap OR the speed strap.
// - Negotiation enable resets to 0 in external mode, else to the negotiation strap.
// - Duplex resets to 0 in external mode, else to NOT negotiation strap AND duplex strap.
`timescale 1ns/1ns
`default_nettype none
`include "pbc_cfg.svh"

module pbc_ctrl #(
   parameter int unsigned PORT_NUM   = 1,
   parameter int unsigned TICK_CYC   = `PBC_TICK_NS / `PBC_CLK_PERIOD_NS,
   parameter int unsigned TIMEOUT_MS = `PBC_AN_TIMEOUT_MS
) (
   input  wire logic                  mclk,
   input  wire logic                  rst,
   input  wire logic                  reg_wr,
   input  wire logic [15:0]           reg_wdata,
   output logic      [15:0]           reg_rdata,
   input  wire logic                  external_mode,
   input  wire logic                  autoneg_strap,
   input  wire logic                  speed_strap,
   input  wire logic                  duplex_strap,
   input  wire logic                  tx_active,
   input  wire logic                  line_collision,
   input  wire pbc_pkg::pbc_partner_t partner,
   output pbc_pkg::pbc_link_cfg_t     link_cfg,
   output logic                       autoneg_complete
);
   import pbc_pkg::*;

   pbc_ctrl_state_t st_q;
   pbc_ctrl_state_t st_d;

   logic ext_q;
   logic neg_start;
   logic neg_enable;
   logic neg_complete;
   logic neg_100;
   logic neg_full;
   logic an_rise;
   logic pwr_fall;

   // Writable field mask; everything else is read-only zero
   function automatic logic [15:0] writable_mask();
      logic [15:0] m;
      m = 16'h0000;
      m[`PBC_BIT_SPEED]      = 1'b1;
      m[`PBC_BIT_AN_EN]      = 1'b1;
      m[`PBC_BIT_PWR_DWN]    = 1'b1;
      m[`PBC_BIT_AN_RESTART] = 1'b1;
      m[`PBC_BIT_DUPLEX]     = 1'b1;
      m[`PBC_BIT_COL_TEST]   = 1'b1;
      return m;
   endfunction : writable_mask

   // Pack the fields into register layout
   function automatic logic [15:0] pack_fields(input pbc_ctrl_state_t s);
      logic [15:0] v;
      v = 16'h0000;
      v[`PBC_BIT_SPEED]      = s.speed_select;
      v[`PBC_BIT_AN_EN]      = s.autoneg_enable;
      v[`PBC_BIT_PWR_DWN]    = s.power_down;
      v[`PBC_BIT_AN_RESTART] = s.autoneg_restart;
      v[`PBC_BIT_DUPLEX]     = s.duplex_select;
      v[`PBC_BIT_COL_TEST]   = s.collision_test_enable;
      return v & writable_mask();
   endfunction : pack_fields

   // External mode only exists on the first port
   always_comb begin
      ext_q = (PORT_NUM == 1) && external_mode;
   end

   // Negotiation start events
   always_comb begin
      an_rise  = reg_wr && reg_wdata[`PBC_BIT_AN_EN] && !st_q.autoneg_enable;
      pwr_fall = reg_wr && !reg_wdata[`PBC_BIT_PWR_DWN] && st_q.power_down;
   end

   // Power down also holds negotiation off, whatever bit 12 says
   assign neg_enable = st_q.autoneg_enable && !st_q.power_down;

   // Negotiation starts from the self-clearing restart bit (bit 9)
   assign neg_start = st_q.autoneg_restart;

   always_comb begin
      st_d = st_q;
      if (st_q.autoneg_restart) begin
         st_d.autoneg_restart = 1'b0;
      end
      if (reg_wr) begin
         st_d.speed_select          = reg_wdata[`PBC_BIT_SPEED];
         st_d.autoneg_enable        = reg_wdata[`PBC_BIT_AN_EN];
         st_d.power_down            = reg_wdata[`PBC_BIT_PWR_DWN];
         st_d.duplex_select         = reg_wdata[`PBC_BIT_DUPLEX];
         st_d.collision_test_enable = reg_wdata[`PBC_BIT_COL_TEST];
         // Restart request, set wins over self clear
         if (reg_wdata[`PBC_BIT_AN_RESTART]) begin
            st_d.autoneg_restart = 1'b1;
         end
      end
      // Enabling or waking starts negotiation too
      if (an_rise || (pwr_fall && reg_wdata[`PBC_BIT_AN_EN])) begin
         st_d.autoneg_restart = 1'b1;
      end
      st_d.rdata = pack_fields(st_d);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q.speed_select          <= ext_q ? `PBC_RST_EXT_SPEED
                                             : (autoneg_strap | speed_strap);
         st_q.autoneg_enable        <= ext_q ? `PBC_RST_EXT_AN_EN : autoneg_strap;
         st_q.duplex_select         <= ext_q ? `PBC_RST_EXT_DUPLEX
                                             : (!autoneg_strap & duplex_strap);
         st_q.power_down            <= `PBC_RST_PWR_DWN;
         st_q.collision_test_enable <= `PBC_RST_COL_TEST;
         // Strap-enabled negotiation starts once out of reset
         st_q.autoneg_restart       <= ext_q ? `PBC_RST_AN_RESTART : autoneg_strap;
         st_q.rdata                 <= 16'h0000;
      end else begin
         st_q <= st_d;
      end
   end

   pbc_negotiator #(
      .TICK_CYC   (TICK_CYC),
      .TIMEOUT_MS (TIMEOUT_MS)
   ) u_neg (
      .mclk        (mclk),
      .rst         (rst),
      .start       (neg_start),
      .enable      (neg_enable),
      .partner     (partner),
      .complete    (neg_complete),
      .speed_100   (neg_100),
      .full_duplex (neg_full)
   );

   always_comb begin
      // Manual speed used only with negotiation off
      link_cfg.speed_100   = st_q.autoneg_enable ? neg_100 : st_q.speed_select;
      link_cfg.full_duplex = st_q.autoneg_enable ? neg_full : st_q.duplex_select;
      link_cfg.power_down  = st_q.power_down;
      link_cfg.collision   = line_collision
                             || (st_q.collision_test_enable && tx_active);
   end

   assign reg_rdata        = st_q.rdata;
   assign autoneg_complete = neg_complete;

endmodule : pbc_ctrl
`default_nettype wire

// [bench/pbc_ctrl_sva.sv]
/* Port checker for the basic control block.
   Assumes it is bound to pbc_ctrl and sees one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module pbc_ctrl_sva (
   input wire logic                   mclk,
   input wire logic                   rst,
   input wire logic                   reg_wr,
   input wire logic [15:0]            reg_wdata,
   input wire logic [15:0]            reg_rdata,
   input wire logic                   external_mode,
   input wire logic                   autoneg_strap,
   input wire logic                   speed_strap,
   input wire logic                   duplex_strap,
   input wire logic                   tx_active,
   input wire logic                   line_collision,
   input wire pbc_pkg::pbc_partner_t  partner,
   input wire pbc_pkg::pbc_link_cfg_t link_cfg,
   input wire logic                   autoneg_complete
);
   import pbc_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);
   sequence s_wr; reg_wr; endsequence
   sequence s_pulse9; reg_rdata[9] ##1 !reg_rdata[9]; endsequence
   // Bit 9 is masked: enabling bit 12 may also raise it
   property p_write; s_wr |=> (reg_rdata & 16'h3980) == ($past(reg_wdata) & 16'h3980); endproperty
   property p_restart; s_wr and reg_wdata[9] |=> s_pulse9; endproperty
   property p_rsvd; reg_rdata[10] == 1'b0 && reg_rdata[6:0] == 7'h00; endproperty
   property p_speed; !$past(rst) && !reg_rdata[12] |-> link_cfg.speed_100 == reg_rdata[13]; endproperty
   property p_duplex; !$past(rst) && !reg_rdata[12] |-> link_cfg.full_duplex == reg_rdata[8]; endproperty
   property p_pwr; !$past(rst) |-> link_cfg.power_down == reg_rdata[11]; endproperty
   property p_col;
      !$past(rst) |-> link_cfg.collision == (line_collision | (reg_rdata[7] & tx_active));
   endproperty
   property p_drop; s_wr and (reg_wdata[11] || !reg_wdata[12]) |-> ##2 !autoneg_complete; endproperty
   property p_rel; $fell(rst) |-> !autoneg_complete && reg_rdata == 16'h0000; endproperty
   a_write: assert property (p_write) else $error("write not reflected");
   a_restart: assert property (p_restart) else $error("restart bit not one cycle");
   a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
   a_speed: assert property (p_speed) else $error("manual speed not applied");
   a_duplex: assert property (p_duplex) else $error("manual duplex not applied");
   a_pwr: assert property (p_pwr) else $error("power down mismatch");
   a_col: assert property (p_col) else $error("collision output wrong");
   a_drop: assert property (p_drop) else $error("complete flag not dropped");
   a_rel: assert property (p_rel) else $error("state after release wrong");
endmodule : pbc_ctrl_sva
`default_nettype wire

// [bench/pbc_ctrl_test.sv]
/* Self-checking bench for pbc_ctrl.
   Assumes shortened negotiation counts and inputs driven at falling edges. */
`timescale 1ns/1ns
`default_nettype none
module pbc_ctrl_test;
   import pbc_pkg::*;
   typedef struct packed {
      logic [15:0] wd; logic tx; logic [15:0] rd; logic [3:0] lk;
   } pbc_row_t;
   localparam pbc_row_t ROWS [6] = '{'{16'h25FF, 1'b1, 16'h2180, 4'hD},
      '{16'h25FF, 1'b0, 16'h2180, 4'hC}, '{16'h0800, 1'b1, 16'h0800, 4'h2},
      '{16'h2000, 1'b1, 16'h2000, 4'h8}, '{16'h0100, 1'b1, 16'h0100, 4'h4},
      '{16'h0000, 1'b1, 16'h0000, 4'h0}};
   logic          mclk, rst, reg_wr, external_mode, autoneg_strap, speed_strap;
   logic          duplex_strap, tx_active, line_collision, autoneg_complete;
   logic [15:0]   reg_wdata, reg_rdata, e, reg_rdata2, e2;
   pbc_partner_t  partner;
   pbc_link_cfg_t link_cfg;
   int            n_mismatch, checks, cyc, k;
   pbc_ctrl #(.PORT_NUM(1), .TICK_CYC(4), .TIMEOUT_MS(5)) pbc_ctrl_inst (
      .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .external_mode(external_mode),
      .autoneg_strap(autoneg_strap), .speed_strap(speed_strap),
      .duplex_strap(duplex_strap), .tx_active(tx_active),
      .line_collision(line_collision), .partner(partner), .link_cfg(link_cfg),
      .autoneg_complete(autoneg_complete));
   // Second port ignores external mode
   pbc_ctrl #(.PORT_NUM(2), .TICK_CYC(4), .TIMEOUT_MS(5)) pbc_ctrl_inst2 (
      .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata2), .external_mode(external_mode),
      .autoneg_strap(autoneg_strap), .speed_strap(speed_strap),
      .duplex_strap(duplex_strap), .tx_active(tx_active),
      .line_collision(line_collision), .partner(partner), .link_cfg(),
      .autoneg_complete());
   task automatic cmp16(input logic [15:0] g, input logic [15:0] x);
      checks++;
      if (g !== x) begin
         n_mismatch++;
         $display("CHECK FAILED %0t register got %h exp %h", $time, g, x);
      end
   endtask : cmp16
   task automatic cmp4(input logic [3:0] g, input logic [3:0] x);
      checks++;
      if (g !== x) begin
         n_mismatch++;
         $display("CHECK FAILED %0t link got %h exp %h", $time, g, x);
      end
   endtask : cmp4
   task automatic wr(input logic [15:0] d);
      @(negedge mclk);
      reg_wr = 1'b1;
      reg_wdata = d;
      @(negedge mclk);
      reg_wr = 1'b0;
   endtask : wr
   task automatic do_rst(input logic [3:0] s);
      @(negedge mclk);
      {external_mode, autoneg_strap, speed_strap, duplex_strap} = s;
      rst = 1'b1;
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      repeat (3) @(negedge mclk);
   endtask : do_rst
   // Bounded wait, well above the shortened fallback count
   task automatic wait_done();
      for (int i = 0; i < 60 && autoneg_complete !== 1'b1; i++) @(negedge mclk);
      cmp4({3'h0, autoneg_complete}, 4'h1);
   endtask : wait_done
   task automatic final_report();
      if (n_mismatch == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : final_report
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      {rst, reg_wr, reg_wdata, tx_active, line_collision} = '0;
      {external_mode, autoneg_strap, speed_strap, duplex_strap} = '0;
      {partner, n_mismatch, checks, cyc} = '0;
      for (k = 0; k < 16; k++) begin
         do_rst(k[3:0]);
         e = 16'h0000;
         e[13] = k[3] | k[2] | k[1];
         e[12] = !k[3] & k[2];
         e[8] = !k[3] & !k[2] & k[0];
         cmp16(reg_rdata, e);
         e2 = 16'h0000;
         e2[13] = k[2] | k[1];
         e2[12] = k[2];
         e2[8] = !k[2] & k[0];
         cmp16(reg_rdata2, e2);
      end
      do_rst(4'h0);
      for (k = 0; k < 6; k++) begin
         tx_active = ROWS[k].tx;
         wr(ROWS[k].wd);
         @(negedge mclk);
         cmp16(reg_rdata, ROWS[k].rd);
         cmp4(link_cfg, ROWS[k].lk);
      end
      line_collision = 1'b1;
      @(negedge mclk);
      cmp4(link_cfg, 4'h1);
      line_collision = 1'b0;
      // Negotiated result must win over opposite manual bits
      partner = '{ok: 1'b1, speed_100: 1'b0, full_duplex: 1'b1};
      wr(16'h3200);
      cmp16(reg_rdata, 16'h3200);
      @(negedge mclk);
      cmp16(reg_rdata, 16'h3000);
      wait_done();
      cmp4(link_cfg, 4'h4);
      wr(16'h0000);
      wr(16'h0800);
      cmp4(link_cfg, 4'h2);
      cmp4({3'h0, autoneg_complete}, 4'h0);
      partner = '{ok: 1'b0, speed_100: 1'b1, full_duplex: 1'b1};
      wr(16'h1000);
      wait_done();
      cmp4(link_cfg, 4'h0);
      final_report();
   end
endmodule : pbc_ctrl_test
bind pbc_ctrl pbc_ctrl_sva pbc_ctrl_sva_inst (
   .mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rdata(reg_rdata), .external_mode(external_mode),
   .autoneg_strap(autoneg_strap), .speed_strap(speed_strap),
   .duplex_strap(duplex_strap), .tx_active(tx_active),
   .line_collision(line_collision), .partner(partner), .link_cfg(link_cfg),
   .autoneg_complete(autoneg_complete));
`default_nettype wire
